//--- inc/ea_pkg.sv
package ea_pkg;
  // word and address widths
  localparam int AW = 15;
  localparam int DW = 16;
  localparam int PAW = 12;
  localparam int COUNT_W = 16;

  // first-word field positions and the flag bit of fetched words
  localparam int OP_HI = 15;
  localparam int OP_LO = 12;
  localparam int M_HI = 11;
  localparam int M_LO = 9;
  localparam int LOW_HI = 8;
  localparam int LOW_LO = 0;
  localparam int SUB_HI = 8;
  localparam int SUB_LO = 3;
  localparam int XS_HI = 2;
  localparam int XS_LO = 0;
  localparam int POST_BIT = 7;
  localparam int IND_BIT = 15;

  // operation codes
  localparam logic [3:0] OP_SYS = 4'h0;
  localparam logic [3:0] OP_IO = 4'h8;

  // addressing selector codes of the first word
  localparam logic [2:0] M_DIR_MAX = 3'h3;
  localparam logic [2:0] M_REL = 3'h4;
  localparam logic [2:0] M_XIDX = 3'h5;
  localparam logic [2:0] M_BIDX = 3'h6;
  localparam logic [2:0] M_IND = 3'h7;
  localparam logic [2:0] M_JUMP = 3'h1;
  localparam logic [2:0] M_MARK = 3'h2;
  localparam logic [2:0] M_EXEC = 3'h3;
  localparam logic [2:0] M_EXT = 3'h6;

  // first-word bits 0-2 selector codes of extended instructions
  localparam logic [2:0] X_IMM_MAX = 3'h3;
  localparam logic [2:0] X_IMM = 3'h0;
  localparam logic [2:0] X_XIDX = 3'h5;
  localparam logic [2:0] X_BIDX = 3'h6;
  localparam logic [2:0] X_MEM = 3'h7;

  // indirection depth and operand length
  localparam logic [2:0] LIM_ONE = 3'h5;
  localparam logic [2:0] LIM_TWO = 3'h4;
  localparam logic [2:0] LVL_FIRST = 3'h1;
  localparam logic [2:0] LVL_STEP = 3'h1;
  localparam logic [2:0] WC_ONE = 3'h1;
  localparam logic [2:0] WC_SP = 3'h2;
  localparam logic [2:0] WC_DP = 3'h4;

  // address arithmetic constants
  localparam logic [14:0] P_STEP = 15'h0001;
  localparam logic [5:0] PAGE0_PAD = 6'h00;
  localparam logic [3:0] DIR_PAD = 4'h0;

  // apb register map
  localparam logic [11:0] CTRL_OFF = 12'h000;
  localparam logic [11:0] STAT_OFF = 12'h004;
  localparam logic [11:0] LAST_EA_OFF = 12'h008;
  localparam logic [11:0] COUNT_OFF = 12'h00c;
  localparam int CTRL_EN_BIT = 0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_FAULT_BIT = 1;
  localparam logic CTRL_EN_RST = 1'b1;

  typedef enum logic [1:0] {ST_IDLE, ST_WORD2, ST_INDIR, ST_DONE} state_type;

  typedef struct packed {
    logic [3:0] op;
    logic [2:0] mode;
    logic [8:0] low;
    logic [2:0] xsel;
    logic [5:0] subop;
    logic post;
    logic single;
    logic dbl;
    logic ext;
    logic imm;
  } fields_type;
endpackage

//--- inc/ea_mem_if.sv
`timescale 1ns/1ps
interface ea_mem_if;
  logic start;
  logic [14:0] addr;
  logic done;
  logic [15:0] data;
  modport client (output start, output addr, input done, input data);
  modport server (input start, input addr, output done, output data);
endinterface

//--- rtl/ea_field_split.sv
`timescale 1ns/1ps
module ea_field_split (
  // first instruction word
  input wire logic [15:0] word_i,
  // decoded fields
  output ea_pkg::fields_type fld_o
);
  wire logic [3:0] op_w = word_i[ea_pkg::OP_HI:ea_pkg::OP_LO];
  wire logic [2:0] mode_w = word_i[ea_pkg::M_HI:ea_pkg::M_LO];
  wire logic [8:0] low_w = word_i[ea_pkg::LOW_HI:ea_pkg::LOW_LO];
  wire logic [2:0] xsel_w = word_i[ea_pkg::XS_HI:ea_pkg::XS_LO];
  wire logic sys_w = op_w == ea_pkg::OP_SYS;
  wire logic dbl_w = sys_w && (mode_w == ea_pkg::M_JUMP || mode_w == ea_pkg::M_MARK ||
    mode_w == ea_pkg::M_EXEC || mode_w == ea_pkg::M_EXT);
  wire logic ext_w = sys_w && mode_w == ea_pkg::M_EXT;

  assign fld_o.op = op_w;
  assign fld_o.mode = mode_w;
  assign fld_o.low = low_w;
  assign fld_o.xsel = xsel_w;
  assign fld_o.subop = word_i[ea_pkg::SUB_HI:ea_pkg::SUB_LO];
  assign fld_o.post = word_i[ea_pkg::POST_BIT];
  assign fld_o.single = !sys_w && op_w != ea_pkg::OP_IO;
  assign fld_o.dbl = dbl_w;
  assign fld_o.ext = ext_w;
  assign fld_o.imm = ext_w && xsel_w == ea_pkg::X_IMM;
endmodule // ea_field_split

//--- rtl/ea_mem_port.sv
`timescale 1ns/1ps
module ea_mem_port (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // decoder side
  ea_mem_if.server rd,
  // memory side
  output logic mem_req_o,
  output logic [14:0] mem_addr_o,
  input wire logic mem_ack_i,
  input wire logic [15:0] mem_data_i
);
  logic req_q;
  logic [14:0] addr_q;
  logic done_q;
  logic [15:0] data_q;

  // request and address stay put until the memory acknowledges
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      req_q <= 1'b0;
      addr_q <= '0;
      done_q <= 1'b0;
      data_q <= '0;
    end else begin
      done_q <= req_q && mem_ack_i;
      if (rd.start) begin
        req_q <= 1'b1;
        addr_q <= rd.addr;
      end else if (mem_ack_i) begin
        req_q <= 1'b0;
      end
      if (req_q && mem_ack_i) begin
        data_q <= mem_data_i;
      end
    end
  end

  assign mem_req_o = req_q;
  assign mem_addr_o = addr_q;
  assign rd.done = done_q;
  assign rd.data = data_q;
endmodule // ea_mem_port

//--- rtl/instr_format_ea_decode.sv
`timescale 1ns/1ps
// Summary of operation
// - split word into op, selector, low field
// - op zero, selector 1/2/3/6: double-word
// - second word is address, top bit defers
// - extended: bits 0-2 selector, 3-8 opcode
// - immediate: second word is the operand
// - immediate operand gets no address modification
// - float: fetch deferrable address, 2/4 words
// - selector 0-3: 11-bit direct address
// - selector 4: low plus counter plus one
// - selector 5: low plus first offset
// - selector 6: low plus second offset
// - selector 7: word in page zero addresses
// - extended 0-3: second word is operand
// - extended 4: second word plus counter plus one
// - extended 5: second word plus first offset
// - extended 6: second word plus second offset
// - extended 7, top clear: 15-bit direct
// - extended 7, top set: indirect location
// - set flag on fetched word chains further
// - chain limit five single, four double
// - bit 7 picks pre or post indexing
module instr_format_ea_decode (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // decode request from the cpu
  input wire logic start_i,
  input wire logic [15:0] first_word_i,
  input wire logic float_unit_selector_i,
  input wire logic float_double_i,
  input wire logic [14:0] counter_i,
  input wire logic [14:0] x_reg_i,
  input wire logic [14:0] b_reg_i,
  // main memory read port
  output logic mem_req_o,
  output logic [14:0] mem_addr_o,
  input wire logic mem_ack_i,
  input wire logic [15:0] mem_data_i,
  // decode result
  output logic busy_o,
  output logic done_o,
  output logic addr_valid_o,
  output logic imm_o,
  output logic fault_o,
  output logic [14:0] ea_o,
  output logic [15:0] operand_o,
  output logic [2:0] word_count_o,
  output logic [3:0] opcode_o,
  output logic [5:0] subop_o
);
  // wrapping adder shared by the relative and indexed address modes
  function automatic logic [14:0] ea_add(input logic [14:0] a, input logic [14:0] b);
    logic [15:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[14:0];
  endfunction

  ea_mem_if rd ();
  ea_pkg::fields_type fw;
  ea_pkg::fields_type fld_q;
  ea_pkg::state_type state_q;
  ea_pkg::state_type state_d;
  logic [14:0] ea_q, ea_d;
  logic [15:0] opnd_q, opnd_d;
  logic [2:0] lvl_q, lvl_d;
  logic [2:0] lim_q, lim_d;
  logic post_q, post_d;
  logic fault_q, fault_d;
  logic imm_q, imm_d;
  logic av_q, av_d;
  logic [14:0] p1_q, x_q, b_q;
  logic flt_q;
  logic [2:0] words_q;
  logic ctrl_en_q;
  logic sticky_q;
  logic [ea_pkg::COUNT_W-1:0] count_q;
  logic [31:0] prdata_q;
  logic rd_go;
  logic [14:0] rd_addr;

  ea_field_split u_split (
    .word_i(first_word_i),
    .fld_o(fw)
  );

  ea_mem_port u_mem (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .rd(rd.server),
    .mem_req_o(mem_req_o),
    .mem_addr_o(mem_addr_o),
    .mem_ack_i(mem_ack_i),
    .mem_data_i(mem_data_i)
  );

  // request acceptance and single-word address forming
  wire logic acc = state_q == ea_pkg::ST_IDLE && start_i && ctrl_en_q;
  wire logic [14:0] p1_w = ea_add(counter_i, ea_pkg::P_STEP);
  wire logic [14:0] low_w = {ea_pkg::PAGE0_PAD, fw.low};
  wire logic [14:0] dir_w = {ea_pkg::DIR_PAD, fw.mode[1:0], fw.low};
  wire logic [14:0] sw_ea = (fw.mode <= ea_pkg::M_DIR_MAX) ? dir_w :
    (fw.mode == ea_pkg::M_REL) ? ea_add(p1_w, low_w) :
    (fw.mode == ea_pkg::M_XIDX) ? ea_add(x_reg_i, low_w) :
    ea_add(b_reg_i, low_w);

  // second-word handling
  wire logic [14:0] w2a = rd.data[ea_pkg::IND_BIT-1:0];
  wire logic w2i = rd.data[ea_pkg::IND_BIT];
  wire logic is_ext = !flt_q && fld_q.ext;
  wire logic ext_imm = is_ext && fld_q.xsel <= ea_pkg::X_IMM_MAX;
  // float, jump, mark, execute and selector 7 use the word as a plain pointer
  wire logic chain_w = flt_q || !is_ext || fld_q.xsel == ea_pkg::X_MEM;
  wire logic idx_w = fld_q.xsel == ea_pkg::X_XIDX || fld_q.xsel == ea_pkg::X_BIDX;
  wire logic post_w = is_ext && idx_w && fld_q.post;
  wire logic [14:0] base_w = (fld_q.xsel == ea_pkg::X_XIDX) ? x_q :
    (fld_q.xsel == ea_pkg::X_BIDX) ? b_q : p1_q;
  wire logic [14:0] pre_sum = ea_add(base_w, w2a);
  wire logic [14:0] ptr_w = (chain_w || post_w) ? w2a : pre_sum;
  wire logic [14:0] fin_w = post_q ? ea_add(base_w, w2a) : w2a;
  wire logic at_lim = lvl_q == lim_q;

  always_comb begin
    state_d = state_q;
    ea_d = ea_q;
    opnd_d = opnd_q;
    lvl_d = lvl_q;
    lim_d = lim_q;
    post_d = post_q;
    fault_d = fault_q;
    imm_d = imm_q;
    av_d = av_q;
    rd_go = 1'b0;
    rd_addr = '0;
    case (state_q)
      ea_pkg::ST_IDLE: begin
        if (acc) begin
          fault_d = 1'b0;
          imm_d = 1'b0;
          av_d = 1'b1;
          post_d = 1'b0;
          lvl_d = ea_pkg::LVL_FIRST;
          lim_d = ea_pkg::LIM_ONE;
          if (float_unit_selector_i || fw.dbl) begin
            rd_go = 1'b1;
            rd_addr = p1_w;
            lim_d = ea_pkg::LIM_TWO;
            state_d = ea_pkg::ST_WORD2;
          end else if (!fw.single) begin
            av_d = 1'b0;
            state_d = ea_pkg::ST_DONE;
          end else if (fw.mode == ea_pkg::M_IND) begin
            rd_go = 1'b1;
            rd_addr = low_w;
            state_d = ea_pkg::ST_INDIR;
          end else begin
            ea_d = sw_ea;
            state_d = ea_pkg::ST_DONE;
          end
        end
      end
      ea_pkg::ST_WORD2: begin
        if (rd.done) begin
          opnd_d = rd.data;
          if (ext_imm) begin
            // operand sits in the second word itself, nothing is modified
            imm_d = 1'b1;
            ea_d = p1_q;
            state_d = ea_pkg::ST_DONE;
          end else if (w2i) begin
            post_d = post_w;
            rd_go = 1'b1;
            rd_addr = ptr_w;
            state_d = ea_pkg::ST_INDIR;
          end else begin
            ea_d = chain_w ? w2a : pre_sum;
            state_d = ea_pkg::ST_DONE;
          end
        end
      end
      ea_pkg::ST_INDIR: begin
        if (rd.done) begin
          if (w2i && at_lim) begin
            // a runaway chain is stopped rather than left to spin on memory
            fault_d = 1'b1;
            av_d = 1'b0;
            state_d = ea_pkg::ST_DONE;
          end else if (w2i) begin
            lvl_d = lvl_q + ea_pkg::LVL_STEP;
            rd_go = 1'b1;
            rd_addr = w2a;
          end else begin
            ea_d = fin_w;
            state_d = ea_pkg::ST_DONE;
          end
        end
      end
      ea_pkg::ST_DONE: begin
        state_d = ea_pkg::ST_IDLE;
      end
      default: begin
        state_d = ea_pkg::ST_IDLE;
      end
    endcase
  end

  assign rd.start = rd_go;
  assign rd.addr = rd_addr;

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= ea_pkg::ST_IDLE;
      ea_q <= '0;
      opnd_q <= '0;
      lvl_q <= '0;
      lim_q <= ea_pkg::LIM_ONE;
      post_q <= 1'b0;
      fault_q <= 1'b0;
      imm_q <= 1'b0;
      av_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ea_q <= ea_d;
      opnd_q <= opnd_d;
      lvl_q <= lvl_d;
      lim_q <= lim_d;
      post_q <= post_d;
      fault_q <= fault_d;
      imm_q <= imm_d;
      av_q <= av_d;
    end
  end

  // operands of the instruction are frozen at acceptance
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fld_q <= '0;
      p1_q <= '0;
      x_q <= '0;
      b_q <= '0;
      flt_q <= 1'b0;
      words_q <= ea_pkg::WC_ONE;
    end else if (acc) begin
      fld_q <= fw;
      p1_q <= p1_w;
      x_q <= x_reg_i;
      b_q <= b_reg_i;
      flt_q <= float_unit_selector_i;
      words_q <= !float_unit_selector_i ? ea_pkg::WC_ONE :
        float_double_i ? ea_pkg::WC_DP : ea_pkg::WC_SP;
    end
  end

  // apb register file, zero wait states
  wire logic apb_setup = psel_i && !penable_i;
  wire logic apb_wr = psel_i && penable_i && pwrite_i;
  wire logic hit_ctrl = paddr_i == ea_pkg::CTRL_OFF;
  wire logic hit_stat = paddr_i == ea_pkg::STAT_OFF;
  wire logic hit_ea = paddr_i == ea_pkg::LAST_EA_OFF;
  wire logic hit_cnt = paddr_i == ea_pkg::COUNT_OFF;
  wire logic mapped = hit_ctrl || hit_stat || hit_ea || hit_cnt;
  wire logic fault_ev = state_q == ea_pkg::ST_DONE && fault_q;
  wire logic fault_clr = apb_wr && hit_stat && pwdata_i[ea_pkg::STAT_FAULT_BIT];
  wire logic [31:0] stat_w = 32'({sticky_q, busy_o});
  wire logic [31:0] rd_mux = hit_ctrl ? 32'(ctrl_en_q) :
    hit_stat ? stat_w :
    hit_ea ? 32'(ea_q) :
    hit_cnt ? 32'(count_q) : '0;

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_en_q <= ea_pkg::CTRL_EN_RST;
      sticky_q <= 1'b0;
      count_q <= '0;
      prdata_q <= '0;
    end else begin
      if (apb_wr && hit_ctrl) begin
        ctrl_en_q <= pwdata_i[ea_pkg::CTRL_EN_BIT];
      end
      // a fault in the clearing cycle survives the clear
      sticky_q <= fault_ev || (sticky_q && !fault_clr);
      if (state_q == ea_pkg::ST_DONE) begin
        count_q <= count_q + 1'b1;
      end
      if (apb_setup) begin
        prdata_q <= rd_mux;
      end
    end
  end

  assign prdata_o = prdata_q;
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && !mapped;
  assign busy_o = state_q != ea_pkg::ST_IDLE;
  assign done_o = state_q == ea_pkg::ST_DONE;
  assign addr_valid_o = av_q;
  assign imm_o = imm_q;
  assign fault_o = fault_q;
  assign ea_o = ea_q;
  assign operand_o = opnd_q;
  assign word_count_o = words_q;
  assign opcode_o = fld_q.op;
  assign subop_o = fld_q.subop;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);

  wire logic acc_sw = acc && !float_unit_selector_i && !fw.dbl && fw.single;

  direct_ea_a: assert property (acc_sw && fw.mode <= ea_pkg::M_DIR_MAX |=>
    done_o && ea_o == {ea_pkg::DIR_PAD, $past(first_word_i[10:0])})
    else $error("direct address wrong");
  rel_ea_a: assert property (acc_sw && fw.mode == ea_pkg::M_REL |=>
    done_o && ea_o == ea_add($past(counter_i) + ea_pkg::P_STEP, $past(low_w)))
    else $error("relative address wrong");
  xidx_ea_a: assert property (acc_sw && fw.mode == ea_pkg::M_XIDX |=>
    done_o && ea_o == ea_add($past(x_reg_i), $past(low_w)))
    else $error("first offset address wrong");
  bidx_ea_a: assert property (acc_sw && fw.mode == ea_pkg::M_BIDX |=>
    done_o && ea_o == ea_add($past(b_reg_i), $past(low_w)))
    else $error("second offset address wrong");
  page0_read_a: assert property (acc_sw && fw.mode == ea_pkg::M_IND |=>
    mem_req_o && mem_addr_o == $past(low_w) && state_q == ea_pkg::ST_INDIR)
    else $error("page zero pointer read wrong");
  imm_take_a: assert property (state_q == ea_pkg::ST_WORD2 && rd.done && ext_imm |=>
    done_o && imm_o && operand_o == $past(rd.data) && ea_o == p1_q)
    else $error("immediate operand wrong");
  depth_cap_a: assert property (busy_o |-> lvl_q <= lim_q)
    else $error("indirection deeper than limit");
  limit_fault_a: assert property (state_q == ea_pkg::ST_INDIR && rd.done && w2i && at_lim |=>
    done_o && fault_o && !addr_valid_o)
    else $error("chain limit not enforced");
  chain_step_a: assert property (state_q == ea_pkg::ST_INDIR && rd.done && w2i && !at_lim |=>
    state_q == ea_pkg::ST_INDIR && mem_req_o && mem_addr_o == $past(w2a) && lvl_q == $past(lvl_q) + 3'h1)
    else $error("chained indirection step wrong");
  post_idx_a: assert property (state_q == ea_pkg::ST_INDIR && rd.done && !w2i && post_q |=>
    done_o && ea_o == ea_add($past(base_w), $past(w2a)))
    else $error("postindex address wrong");
  float_len_a: assert property (acc && float_unit_selector_i |=>
    word_count_o == ($past(float_double_i) ? ea_pkg::WC_DP : ea_pkg::WC_SP) && state_q == ea_pkg::ST_WORD2)
    else $error("float operand length wrong");

  ind_done_c: cover property (state_q == ea_pkg::ST_INDIR ##1 done_o && !fault_o);
  post_done_c: cover property (post_q && done_o);
  fault_c: cover property (done_o && fault_o);
  imm_c: cover property (done_o && imm_o);
endmodule // instr_format_ea_decode

//--- verif/ea_mem_model.sv
`timescale 1ns/1ps
module ea_mem_model (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // read port
  input wire logic mem_req_i,
  input wire logic [14:0] mem_addr_i,
  output logic mem_ack_o,
  output logic [15:0] mem_data_o
);
  logic [15:0] mem [0:32767];
  int wait_cycles;
  int cnt;
  initial begin
    wait_cycles = 0;
    cnt = 0;
    mem_ack_o = 1'b0;
    mem_data_o = 16'h0000;
  end
  // ack for one cycle only; data flips when not acking so stale reads show up
  always @(posedge core_clk_i) begin
    if (rst_b_i && mem_req_i && !mem_ack_o && cnt >= wait_cycles) begin
      mem_ack_o <= 1'b1;
      mem_data_o <= mem[mem_addr_i];
      cnt <= 0;
    end else begin
      if (mem_req_i && !mem_ack_o) begin
        cnt <= cnt + 1;
      end
      mem_ack_o <= 1'b0;
      mem_data_o <= ~mem_data_o;
    end
  end
endmodule // ea_mem_model

//--- verif/tb.sv
`timescale 1ns/1ps
module tb;
  typedef struct packed {
    logic [14:0] ea; logic av; logic imm; logic flt; logic [15:0] opnd; logic [2:0] wc; logic [3:0] op; logic [5:0] sub;
  } exp_type;
  logic core_clk_i, rst_b_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, start_i, fs, fd;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic [15:0] fw, w2, mem_data_i, operand_o;
  logic [14:0] ctr, xr, br, fin, base, ea, mem_addr_o, ea_o;
  logic mem_req_o, mem_ack_i, busy_o, done_o, addr_valid_o, imm_o, fault_o, er;
  logic [2:0] word_count_o;
  logic [3:0] opcode_o;
  logic [5:0] subop_o;
  logic [8:0] low;
  logic [15:0] first_word_i;
  logic [14:0] counter_i, x_reg_i, b_reg_i;
  logic float_unit_selector_i, float_double_i;
  exp_type q[$];
  exp_type e;
  int num_errors, samples_checked, seed, ndone;
  instr_format_ea_decode DUT (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .start_i(start_i), .first_word_i(first_word_i),
    .float_unit_selector_i(float_unit_selector_i), .float_double_i(float_double_i), .counter_i(counter_i),
    .x_reg_i(x_reg_i), .b_reg_i(b_reg_i), .mem_req_o(mem_req_o), .mem_addr_o(mem_addr_o),
    .mem_ack_i(mem_ack_i), .mem_data_i(mem_data_i), .busy_o(busy_o), .done_o(done_o), .addr_valid_o(addr_valid_o),
    .imm_o(imm_o), .fault_o(fault_o), .ea_o(ea_o), .operand_o(operand_o), .word_count_o(word_count_o),
    .opcode_o(opcode_o), .subop_o(subop_o));
  ea_mem_model u_mem (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .mem_req_i(mem_req_o), .mem_addr_i(mem_addr_o),
    .mem_ack_o(mem_ack_i), .mem_data_o(mem_data_i));
  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks=%0d errors=%0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // results are compared in the done cycle, before that edge's updates land
  always @(posedge core_clk_i) begin
    if (done_o === 1'b1) begin
      if (q.size() == 0) begin
        check(48'h1, 48'h0);
      end else begin
        e = q.pop_front();
        check(fault_o, e.flt);
        check(word_count_o, e.wc);
        check({opcode_o, subop_o}, {e.op, e.sub});
        check(imm_o, e.imm);
        if (e.imm) begin
          check({imm_o, operand_o, ea_o}, {1'b1, e.opnd, e.ea});
        end else if (!e.flt) begin
          check({addr_valid_o, ea_o & {15{e.av}}}, {e.av, e.ea & {15{e.av}}});
        end
      end
    end
  end
  function automatic exp_type mk(input logic [14:0] a, input logic av, input logic im, input logic fl,
                                 input logic [2:0] wc);
    mk = '{a, av, im, fl, w2, wc, fw[15:12], fw[8:3]};
  endfunction
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge core_clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge core_clk_i);
      if (pready_o === 1'b1) break;
    end
    if (i == 50) begin
      num_errors++;
      close_out();
    end
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic pulse();
    @(posedge core_clk_i);
    // staged values reach the decoder only here, on the clock edge
    start_i <= 1'b1;
    first_word_i <= fw;
    counter_i <= ctr;
    x_reg_i <= xr;
    b_reg_i <= br;
    float_unit_selector_i <= fs;
    float_double_i <= fd;
    @(posedge core_clk_i);
    start_i <= 1'b0;
  endtask
  task automatic dec(input exp_type x);
    int i;
    u_mem.mem[ctr + 15'h0001] = w2;
    q.push_back(x);
    ndone++;
    pulse();
    for (i = 0; i < 300; i++) begin
      @(negedge core_clk_i);
      if (busy_o === 1'b0) break;
    end
    if (i == 300) begin
      num_errors++;
      close_out();
    end
  endtask
  // n flagged links from address at, then the final pointer to fin
  task automatic set_chain(input logic [14:0] at, input int n);
    for (int k = 0; k < n; k++) begin
      u_mem.mem[at] = {1'b1, 15'h4000 + 15'(k)};
      at = 15'h4000 + 15'(k);
    end
    u_mem.mem[at] = {1'b0, fin};
  endtask
  initial begin
    {psel_i, penable_i, pwrite_i, start_i, fs, fd} = 6'h00;
    {paddr_i, pwdata_i, fw, w2, ctr, xr, br} = '0;
    {first_word_i, counter_i, x_reg_i, b_reg_i, float_unit_selector_i, float_double_i} = '0;
    rst_b_i = 1'b0;
    seed = 50624;
    repeat (4) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    check(rd, 32'h1);
    for (int m = 0; m < 14; m++) begin
      ctr = 15'h2000 | 15'($random(seed) & 32'h0fff);
      xr = 15'($random(seed) & 32'h07ff);
      br = 15'($random(seed));
      low = 9'($random(seed));
      fin = 15'($random(seed));
      w2 = 16'h0000;
      fs = 1'b0;
      u_mem.wait_cycles = m % 3;
      if (m == 4) ctr = 15'h7ffe;
      fw = {(m < 4) ? 4'h3 : 4'hc, 3'(m), low};
      ea = (m < 4) ? {4'h0, fw[10:9], low} : (m == 4) ? ctr + 15'h0001 + {6'h00, low} : (m == 5) ?
           xr + {6'h00, low} : br + {6'h00, low};
      if (m >= 7) begin
        fw[11:9] = 3'h7;
        set_chain({6'h00, low}, m - 8);
        ea = fin;
      end
      dec(mk(ea, 1'b1, 1'b0, m == 13, 3'h1));
    end
    apb(1'b0, 12'h004, 32'h0);
    check(rd, 32'h2);
    apb(1'b1, 12'h004, 32'h2);
    apb(1'b0, 12'h004, 32'h0);
    check(rd, 32'h0);
    ctr = 15'h2400;
    fin = 15'h1234;
    for (int m = 1; m < 4; m++) begin
      fw = {4'h0, 3'(m), 9'h0a5};
      w2 = {m == 2, 15'h6000};
      set_chain(15'h6000, 0);
      dec(mk((m == 2) ? fin : 15'h6000, 1'b1, 1'b0, 1'b0, 3'h1));
    end
    for (int m = 0; m < 4; m++) begin
      fw = {4'h0, 3'h6, 6'(m + 5), 3'(m)};
      w2 = 16'($random(seed)) | {m[0], 15'h0000};
      dec(mk(ctr + 15'h0001, 1'b1, 1'b1, 1'b0, 3'h1));
    end
    fw = 16'h0c04;
    w2 = 16'h0777;
    dec(mk(ctr + 15'h0778, 1'b1, 1'b0, 1'b0, 3'h1));
    for (int m = 0; m < 8; m++) begin
      base = m[2] ? br : xr;
      fw = {4'h0, 3'h6, 1'b0, m[1], 4'h2, m[2] ? 3'h6 : 3'h5};
      w2 = {m[0], 15'h6800};
      u_mem.mem[m[1] ? 15'h6800 : 15'h6800 + base] = {1'b0, fin};
      ea = !m[0] ? 15'h6800 + base : m[1] ? fin + base : fin;
      dec(mk(ea, 1'b1, 1'b0, 1'b0, 3'h1));
    end
    for (int m = 0; m < 6; m++) begin
      fw = 16'h0c17;
      w2 = {m != 5, 15'h6000};
      u_mem.wait_cycles = m % 2;
      set_chain(15'h6000, (m == 5) ? 0 : m);
      dec(mk((m == 5) ? 15'h6000 : fin, 1'b1, 1'b0, m == 4, 3'h1));
    end
    for (int m = 0; m < 2; m++) begin
      fs = 1'b1;
      fd = m[0];
      fw = 16'hf0c3;
      w2 = {1'b1, 15'h6000};
      set_chain(15'h6000, 1);
      dec(mk(fin, 1'b1, 1'b0, 1'b0, m[0] ? 3'h4 : 3'h2));
    end
    fs = 1'b0;
    fw = 16'h8123;
    dec(mk(15'h0000, 1'b0, 1'b0, 1'b0, 3'h1));
    fw = 16'h0012;
    dec(mk(15'h0000, 1'b0, 1'b0, 1'b0, 3'h1));
    apb(1'b1, 12'h000, 32'h0);
    pulse();
    // a taken start would already show busy at this negedge
    @(negedge core_clk_i);
    check(busy_o, 48'h0);
    apb(1'b1, 12'h000, 32'h1);
    apb(1'b0, 12'h010, 32'h0);
    check({er, rd}, {1'b1, 32'h0});
    apb(1'b0, 12'h00c, 32'h0);
    check(rd, 32'(16'(ndone)));
    check(q.size(), 0);
    close_out();
  end
endmodule // tb
